// File: common/pwrmon_defs.vh
// Constants for the power monitor result and alert block
`ifndef PWRMON_DEFS_VH
`define PWRMON_DEFS_VH

// Register word indices, one aligned word each; the byte address is four times the index
`define OFS_CONFIG 4'h0
`define OFS_ADC_CONFIG 4'h1
`define OFS_CALIB 4'h2
`define OFS_ALERT_CTRL 4'h3
`define OFS_SHUNT_LIMIT 4'h4
`define OFS_BUS_LIMIT 4'h5
`define OFS_POWER_LIMIT 4'h6
`define OFS_SHUNT_RES 4'h7
`define OFS_BUS_RES 4'h8
`define OFS_TEMP_RES 4'h9
`define OFS_CURRENT_RES 4'hA
`define OFS_POWER_RES 4'hB
`define OFS_STATUS 4'hC

// Power-on values
`define RST_CONFIG 16'h0000
`define RST_ADC_CONFIG 16'hF000
`define RST_CALIB 16'h0000
`define RST_ALERT_CTRL 16'h0000
`define RST_SHUNT_LIMIT 16'h7FFF
`define RST_BUS_LIMIT 16'h7FFF
`define RST_POWER_LIMIT 16'hFFFF

// Field positions
`define CFG_RANGE_BIT 4
`define ADC_MODE_HI 15
`define ADC_MODE_LO 12
`define ADC_BUS_CT_HI 11
`define ADC_BUS_CT_LO 9
`define ADC_SH_CT_HI 8
`define ADC_SH_CT_LO 6
`define ADC_AVG_HI 2
`define ADC_AVG_LO 0
`define ACT_READY_SEL_BIT 0
`define ACT_AVG_SEL_BIT 1

// Mode bits: bit0 shunt, bit1 bus, bit2 temperature, bit3 continuous
`define MODE_SHUNT_BIT 12
`define MODE_BUS_BIT 13
`define MODE_TEMP_BIT 14
`define MODE_CONT_BIT 15

// Base conversion time in cycles of 250 MHz: 50 us
`define CONV_BASE_US 50
`define CLK_MHZ 250
`define CONV_BASE_CYC (`CONV_BASE_US * `CLK_MHZ)

// Power scale: one LSB = current LSB * 0.2, as 1/5
`define POWER_DIV 5

`define ADDR_W 4
`define WORD_ZERO 32'h0000_0000
`define HALF_ZERO 16'h0000
`endif

// File: verilog/pwrmon_core.v
// Power monitor: register file, conversion sequencer, limits and alert
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "pwrmon_defs.vh"

// Notes on behaviour
// - Separate shunt/bus times; independent averaging count
// - Power-on defaults: wide range, continuous all
// - Limit registers return to defaults on reset
// - Zero calibration forces current, power zero
// - Register bit selects narrow or wide range
// - Shunt result compared against shunt upper limit
// - Bus result compared against bus upper limit
// - Power limit compares upper sixteen power bits
// - Power equals current magnitude times bus over five
// - Results are two's complement, bus positive, power unsigned
// - Alert selects limit fault or conversion ready
// - Alert follows the fault flags one clock after the result that sets them
module pwrmon_core
(
  input wire CLK,
  input wire RESETN,
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  output reg [1:0] AVS_RESPONSE,
  input wire [15:0] SHUNT_SAMPLE,
  input wire [15:0] BUS_SAMPLE,
  input wire [15:0] TEMP_SAMPLE,
  output reg ALERT_N,
  output reg SAMPLE_STROBE
);

  // Sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_SHUNT = 2'b01;
  localparam ST_BUS = 2'b10;
  localparam ST_TEMP = 2'b11;

  reg [15:0] config_ff;
  reg [15:0] adc_config_ff;
  reg [15:0] calib_ff;
  reg [15:0] alert_ctrl_ff;
  reg [15:0] shunt_upper_limit_ff;
  reg [15:0] bus_upper_limit_ff;
  reg [15:0] power_limit_ff;
  reg [15:0] shunt_res_ff;
  reg [15:0] bus_res_ff;
  reg [15:0] temp_res_ff;
  reg [15:0] current_res_ff;
  reg [23:0] power_res_ff;
  reg [1:0] state_ff;
  reg [20:0] conv_cnt_ff;
  reg [10:0] avg_cnt_ff;
  reg signed [26:0] acc_ff;
  reg ready_ff;
  reg shunt_flt_ff;
  reg bus_flt_ff;
  reg pwr_flt_ff;
  reg ack_ff;
  reg [15:0] sh_s1_ff;
  reg [15:0] sh_s2_ff;
  reg [15:0] bu_s1_ff;
  reg [15:0] bu_s2_ff;
  reg [15:0] te_s1_ff;
  reg [15:0] te_s2_ff;

  // Base period kept at full width; only its low bits feed the shift
  localparam [31:0] CONV_BASE = `CONV_BASE_CYC;

  // Conversion time in cycles for a 3-bit code: base shifted by the code
  // Twenty-one bits so that the slowest code does not wrap
  function [20:0] conv_cycles;
    input [2:0] code;
    begin
      conv_cycles = CONV_BASE[20:0] << code;
    end
  endfunction

  // Sample count for the averaging code: 1, 4, 16 ... up to 1024
  function [10:0] avg_samples;
    input [2:0] code;
    begin
      if (code > 3'd5)
        avg_samples = 11'd1024;
      else
        avg_samples = 11'd1 << {code[2:0], 1'b0};
    end
  endfunction

  // Byte-lane merge for register writes
  function [15:0] merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  wire [`ADDR_W-1:0] reg_idx = AVS_ADDRESS[5:2];
  wire wr_go = AVS_WRITE && !ack_ff;
  wire rd_go = AVS_READ && !ack_ff;
  // Writes land at the answer edge, when the master sees waitrequest low
  wire wr_fire = AVS_WRITE && ack_ff;
  wire restart = wr_fire && (reg_idx == `OFS_ADC_CONFIG);
  wire [2:0] sh_ct = adc_config_ff[`ADC_SH_CT_HI:`ADC_SH_CT_LO];
  wire [2:0] bu_ct = adc_config_ff[`ADC_BUS_CT_HI:`ADC_BUS_CT_LO];
  wire [2:0] avg_code = adc_config_ff[`ADC_AVG_HI:`ADC_AVG_LO];
  wire range_narrow = config_ff[`CFG_RANGE_BIT];
  wire cont = adc_config_ff[`MODE_CONT_BIT];
  wire [20:0] cur_time = (state_ff == ST_BUS) ? conv_cycles(bu_ct) : conv_cycles(sh_ct);
  wire conv_done = (state_ff != ST_IDLE) && (conv_cnt_ff >= cur_time - 21'd1);
  wire [10:0] avg_n = avg_samples(avg_code);
  wire last_sample = conv_done && (avg_cnt_ff >= avg_n - 11'd1);
  wire signed [15:0] cur_sample = (state_ff == ST_BUS) ? bu_s2_ff :
    (state_ff == ST_TEMP) ? te_s2_ff : sh_s2_ff;
  wire signed [26:0] acc_sum = acc_ff + {{11{cur_sample[15]}}, cur_sample};
  wire [3:0] avg_shift = (avg_code > 3'd5) ? 4'd10 : {avg_code[2:0], 1'b0};
  wire signed [26:0] avg_val = acc_sum >>> avg_shift;
  // Narrow range gives four times finer shunt codes, clipped at full scale
  wire narrow_hi = !avg_val[26] && (avg_val[25:13] != 13'h0000);
  wire narrow_lo = avg_val[26] && (avg_val[25:13] != 13'h1FFF);
  wire signed [15:0] shunt_scaled = !range_narrow ? avg_val[15:0] :
    narrow_hi ? 16'sh7FFF : narrow_lo ? 16'sh8000 : {avg_val[13:0], 2'b00};
  wire signed [31:0] cur_prod = $signed(shunt_scaled) * $signed({1'b0, calib_ff});
  wire signed [15:0] cur_new = (calib_ff == `HALF_ZERO) ? 16'sh0000 : cur_prod[26:11];
  // Power pairs the new bus result with the latest current magnitude
  wire [15:0] cur_mag = current_res_ff[15] ? (~current_res_ff + 16'd1) : current_res_ff;
  wire [31:0] pwr_prod = cur_mag * {1'b0, avg_val[14:0]};
  wire [31:0] pwr_quot = pwr_prod / `POWER_DIV;
  // Saturate rather than wrap when the quotient outgrows 24 bits
  wire [23:0] pwr_new = (calib_ff == `HALF_ZERO) ? 24'h00_0000 :
    (pwr_quot[31:24] != 8'h00) ? 24'hFF_FFFF : pwr_quot[23:0];
  wire fault_any = shunt_flt_ff || bus_flt_ff || pwr_flt_ff;

  // Next state of the sequencer through enabled channels
  reg [1:0] nxt_state;
  always @*
  begin
    nxt_state = ST_IDLE;
    case (state_ff)
      ST_IDLE:
        if (adc_config_ff[`MODE_SHUNT_BIT]) nxt_state = ST_SHUNT;
        else if (adc_config_ff[`MODE_BUS_BIT]) nxt_state = ST_BUS;
        else if (adc_config_ff[`MODE_TEMP_BIT]) nxt_state = ST_TEMP;
      ST_SHUNT:
        if (adc_config_ff[`MODE_BUS_BIT]) nxt_state = ST_BUS;
        else if (adc_config_ff[`MODE_TEMP_BIT]) nxt_state = ST_TEMP;
        else nxt_state = cont ? ST_SHUNT : ST_IDLE;
      ST_BUS:
        if (adc_config_ff[`MODE_TEMP_BIT]) nxt_state = ST_TEMP;
        else if (!cont) nxt_state = ST_IDLE;
        else nxt_state = adc_config_ff[`MODE_SHUNT_BIT] ? ST_SHUNT : ST_BUS;
      ST_TEMP:
        if (!cont) nxt_state = ST_IDLE;
        else if (adc_config_ff[`MODE_SHUNT_BIT]) nxt_state = ST_SHUNT;
        else if (adc_config_ff[`MODE_BUS_BIT]) nxt_state = ST_BUS;
        else nxt_state = ST_TEMP;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // Ready rises on a result that closes a pass over the enabled channels, and on every result while temperature is off
  wire ready_set = last_sample && !restart &&
    (nxt_state == ST_IDLE || state_ff == ST_TEMP || !adc_config_ff[`MODE_TEMP_BIT]);

  // Samples come from the analog side, so two stages first
  // Each word must hold for a few clocks; a change at an edge may tear once
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sh_s1_ff <= `HALF_ZERO;
      sh_s2_ff <= `HALF_ZERO;
      bu_s1_ff <= `HALF_ZERO;
      bu_s2_ff <= `HALF_ZERO;
      te_s1_ff <= `HALF_ZERO;
      te_s2_ff <= `HALF_ZERO;
    end
    else
    begin
      sh_s1_ff <= SHUNT_SAMPLE;
      sh_s2_ff <= sh_s1_ff;
      bu_s1_ff <= BUS_SAMPLE;
      bu_s2_ff <= bu_s1_ff;
      te_s1_ff <= TEMP_SAMPLE;
      te_s2_ff <= te_s1_ff;
    end
  end

  // Register writes; reset is the power cycle restoring every default
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      config_ff <= `RST_CONFIG;
      adc_config_ff <= `RST_ADC_CONFIG;
      calib_ff <= `RST_CALIB;
      alert_ctrl_ff <= `RST_ALERT_CTRL;
      shunt_upper_limit_ff <= `RST_SHUNT_LIMIT;
      bus_upper_limit_ff <= `RST_BUS_LIMIT;
      power_limit_ff <= `RST_POWER_LIMIT;
    end
    else if (wr_fire)
    begin
      case (reg_idx)
        `OFS_CONFIG: config_ff <= merge(config_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        `OFS_ADC_CONFIG: adc_config_ff <= merge(adc_config_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        `OFS_CALIB: calib_ff <= merge(calib_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        `OFS_ALERT_CTRL: alert_ctrl_ff <= merge(alert_ctrl_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        `OFS_SHUNT_LIMIT:
          shunt_upper_limit_ff <= merge(shunt_upper_limit_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        `OFS_BUS_LIMIT:
          bus_upper_limit_ff <= merge(bus_upper_limit_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        `OFS_POWER_LIMIT:
          power_limit_ff <= merge(power_limit_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
        default: ;
      endcase
    end
  end

  // Conversion timing, averaging and result capture
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_ff <= ST_IDLE;
      conv_cnt_ff <= 21'h0_0000;
      avg_cnt_ff <= 11'h000;
      acc_ff <= 27'sh000_0000;
      shunt_res_ff <= `HALF_ZERO;
      bus_res_ff <= `HALF_ZERO;
      temp_res_ff <= `HALF_ZERO;
      current_res_ff <= `HALF_ZERO;
      power_res_ff <= 24'h00_0000;
      ready_ff <= 1'b0;
      shunt_flt_ff <= 1'b0;
      bus_flt_ff <= 1'b0;
      pwr_flt_ff <= 1'b0;
      SAMPLE_STROBE <= 1'b0;
    end
    else
    begin
      SAMPLE_STROBE <= conv_done;
      // A mode write restarts the sequence from idle
      if (restart)
      begin
        state_ff <= ST_IDLE;
        conv_cnt_ff <= 21'h0_0000;
        avg_cnt_ff <= 11'h000;
        acc_ff <= 27'sh000_0000;
      end
      else if (state_ff == ST_IDLE)
      begin
        state_ff <= nxt_state;
        conv_cnt_ff <= 21'h0_0000;
      end
      else if (conv_done)
      begin
        conv_cnt_ff <= 21'h0_0000;
        if (last_sample)
        begin
          avg_cnt_ff <= 11'h000;
          acc_ff <= 27'sh000_0000;
          state_ff <= nxt_state;
          // Each completed shunt and bus result is checked once against its limit; temperature has none
          case (state_ff)
            ST_SHUNT:
            begin
              shunt_res_ff <= shunt_scaled;
              current_res_ff <= cur_new;
              shunt_flt_ff <= $signed(shunt_scaled) > $signed(shunt_upper_limit_ff);
            end
            ST_BUS:
            begin
              bus_res_ff <= {1'b0, avg_val[14:0]};
              power_res_ff <= pwr_new;
              bus_flt_ff <= avg_val[14:0] > bus_upper_limit_ff[14:0];
              pwr_flt_ff <= pwr_new[23:8] > power_limit_ff;
            end
            ST_TEMP:
              temp_res_ff <= avg_val[15:0];
            default: ;
          endcase
          if (ready_set)
            ready_ff <= 1'b1;
        end
        else
        begin
          avg_cnt_ff <= avg_cnt_ff + 11'd1;
          acc_ff <= acc_sum;
        end
      end
      else
        conv_cnt_ff <= conv_cnt_ff + 21'd1;
      // Reading status clears ready; a new ready in the same cycle wins
      if (rd_go && reg_idx == `OFS_STATUS && !ready_set)
        ready_ff <= 1'b0;
    end
  end

  // Alert pin: fault or ready by selection, active low
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      ALERT_N <= 1'b1;
    else if (alert_ctrl_ff[`ACT_READY_SEL_BIT])
      ALERT_N <= !ready_ff;
    else
      ALERT_N <= !fault_any;
  end

  // Avalon slave: one wait cycle, then answer
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_ff <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= `WORD_ZERO;
      AVS_RESPONSE <= 2'b00;
    end
    else
    begin
      ack_ff <= (rd_go || wr_go);
      AVS_WAITREQUEST <= !(rd_go || wr_go);
      AVS_RESPONSE <= (reg_idx > `OFS_STATUS) ? 2'b10 : 2'b00;
      if (rd_go)
      begin
        case (reg_idx)
          `OFS_CONFIG: AVS_READDATA <= {16'h0000, config_ff};
          `OFS_ADC_CONFIG: AVS_READDATA <= {16'h0000, adc_config_ff};
          `OFS_CALIB: AVS_READDATA <= {16'h0000, calib_ff};
          `OFS_ALERT_CTRL: AVS_READDATA <= {16'h0000, alert_ctrl_ff};
          `OFS_SHUNT_LIMIT: AVS_READDATA <= {16'h0000, shunt_upper_limit_ff};
          `OFS_BUS_LIMIT: AVS_READDATA <= {16'h0000, bus_upper_limit_ff};
          `OFS_POWER_LIMIT: AVS_READDATA <= {16'h0000, power_limit_ff};
          `OFS_SHUNT_RES: AVS_READDATA <= {16'h0000, shunt_res_ff};
          `OFS_BUS_RES: AVS_READDATA <= {16'h0000, bus_res_ff};
          `OFS_TEMP_RES: AVS_READDATA <= {16'h0000, temp_res_ff};
          `OFS_CURRENT_RES: AVS_READDATA <= {16'h0000, current_res_ff};
          `OFS_POWER_RES: AVS_READDATA <= {8'h00, power_res_ff};
          `OFS_STATUS:
            AVS_READDATA <= {28'h000_0000, pwr_flt_ff, bus_flt_ff, shunt_flt_ff, ready_ff};
          default: AVS_READDATA <= `WORD_ZERO;
        endcase
      end
    end
  end

endmodule

// File: sim/pwrmon_checker.sv
// Port checker for the power monitor block
`timescale 1ns/100ps
module pwrmon_checker
(
  input wire CLK,
  input wire RESETN,
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  input wire [1:0] AVS_RESPONSE,
  input wire ALERT_N,
  input wire SAMPLE_STROBE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Request and answer qualifiers
  wire req = AVS_READ | AVS_WRITE;
  wire ans = !AVS_WAITREQUEST;
  wire bad = AVS_ADDRESS[5:2] > 4'hC;
  a_answer_next: assert property (req && !ans |=> ans) else $error("answer late");
  a_answer_single: assert property (ans |=> !ans) else $error("answer held");
  a_answer_cause: assert property (ans |-> req) else $error("answer unasked");
  a_bad_code: assert property (ans && bad |-> AVS_RESPONSE == 2'b10) else $error("code");
  a_good_code: assert property (ans && !bad |-> AVS_RESPONSE == 2'b00) else $error("code");
  a_bad_data: assert property (ans && bad && AVS_READ |-> AVS_READDATA == 32'h0000_0000)
    else $error("unmapped data");
  a_upper_clear: assert property (ans && AVS_READ && AVS_ADDRESS[5:2] != 4'hB
    |-> AVS_READDATA[31:16] == 16'h0000) else $error("upper half");
  // Alert may only drop just after a finished result
  a_alert_result: assert property ($fell(ALERT_N)
    |-> $past(SAMPLE_STROBE) || $past(SAMPLE_STROBE, 2)) else $error("alert off result");
  a_strobe_gap: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE [*8])
    else $error("strobe gap");
  a_reset_idle: assert property ($rose(RESETN) |-> ALERT_N && AVS_WAITREQUEST)
    else $error("reset idle");
  c_read: cover property (ans && AVS_READ);
  c_bad: cover property (ans && bad);
  c_alert: cover property ($fell(ALERT_N));
endmodule
bind pwrmon_core pwrmon_checker u_pwrmon_checker
(
  .CLK(CLK),
  .RESETN(RESETN),
  .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_RESPONSE(AVS_RESPONSE),
  .ALERT_N(ALERT_N),
  .SAMPLE_STROBE(SAMPLE_STROBE)
);

// File: sim/pwrmon_sensor_model.sv
// Converter front end model feeding raw codes
`timescale 1ns/100ps
module pwrmon_sensor_model
(
  input wire CLK,
  input wire [15:0] shunt_set,
  input wire [15:0] bus_set,
  input wire SAMPLE_STROBE,
  output wire [15:0] SHUNT_SAMPLE,
  output wire [15:0] BUS_SAMPLE,
  output wire [15:0] TEMP_SAMPLE,
  output int conv_count
);
  // Shunt signed, bus kept positive by clearing its sign bit
  assign SHUNT_SAMPLE = shunt_set;
  assign BUS_SAMPLE = {1'b0, bus_set[14:0]};
  assign TEMP_SAMPLE = 16'h00C8;
  // Finished conversions, so the host never assumes a period
  int count_ff = 0;
  always @(posedge CLK)
    if (SAMPLE_STROBE)
      count_ff <= count_ff + 1;
  assign conv_count = count_ff;
endmodule

// File: sim/power_monitor_result_and_alert_tb.sv
// Self-checking bench for the power monitor block
`timescale 1ns/100ps
`include "pwrmon_defs.vh"
module power_monitor_result_and_alert_tb;
  logic CLK, RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, ALERT_N, SAMPLE_STROBE;
  logic [5:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [3:0] AVS_BYTEENABLE;
  logic [1:0] AVS_RESPONSE, rs;
  logic [15:0] SHUNT_SAMPLE, BUS_SAMPLE, TEMP_SAMPLE, shunt_set, bus_set;
  int n_mismatch = 0;
  int checked = 0;
  int conv_count;
  int lat;
  typedef struct packed {logic [3:0] idx; logic [31:0] exp;} row_t;
  row_t rows[7] = '{'{4'h0, 32'h0000_0000}, '{4'h1, 32'h0000_F000}, '{4'h2, 32'h0000_0000},
    '{4'h3, 32'h0000_0000}, '{4'h4, 32'h0000_7FFF}, '{4'h5, 32'h0000_7FFF},
    '{4'h6, 32'h0000_FFFF}};
  pwrmon_core u_pwrmon_core (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
    .SHUNT_SAMPLE(SHUNT_SAMPLE), .BUS_SAMPLE(BUS_SAMPLE), .TEMP_SAMPLE(TEMP_SAMPLE),
    .ALERT_N(ALERT_N), .SAMPLE_STROBE(SAMPLE_STROBE));
  pwrmon_sensor_model u_pwrmon_sensor_model (.CLK(CLK), .shunt_set(shunt_set),
    .bus_set(bus_set), .SAMPLE_STROBE(SAMPLE_STROBE), .SHUNT_SAMPLE(SHUNT_SAMPLE),
    .BUS_SAMPLE(BUS_SAMPLE), .TEMP_SAMPLE(TEMP_SAMPLE), .conv_count(conv_count));
  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    AVS_WRITEDATA <= {16'h0000, wd};
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge CLK);
    end
    if (n == 50)
    begin
      n_mismatch++;
      final_report;
    end
    rd = AVS_READDATA;
    rs = AVS_RESPONSE;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  // Waits for k finished conversions, bounded
  task automatic results(input int k);
    int c0, n;
    c0 = conv_count;
    n = 0;
    while (conv_count < c0 + k && n < 30000 * k)
    begin
      n++;
      @(posedge CLK);
    end
    if (conv_count < c0 + k)
    begin
      n_mismatch++;
      final_report;
    end
    repeat (4) @(posedge CLK);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    CLK = 0;
    forever #2 CLK = ~CLK;
  end
  // Run should end well before this
  initial
  begin
    #(100000 * 4);
    n_mismatch++;
    final_report;
  end
  initial
  begin
    RESETN = 0;
    AVS_READ = 0;
    AVS_WRITE = 0;
    AVS_ADDRESS = 0;
    AVS_WRITEDATA = 0;
    AVS_BYTEENABLE = 4'hF;
    shunt_set = 16'h0064;
    bus_set = 16'h03E8;
    repeat (3) @(posedge CLK);
    RESETN <= 1;
    foreach (rows[i])
    begin
      bus(0, rows[i].idx, 16'h0000);
      chk("power-on value", rd, rows[i].exp);
    end
    bus(0, 4'hD, 16'h0000);
    chk("unmapped data", rd, 32'h0000_0000);
    chk("unmapped code", {30'h0, rs}, 32'h0000_0002);
    $display("test defaults done");
    bus(1, 4'h0, 16'h0010);
    bus(0, 4'h0, 16'h0000);
    chk("range select", rd, 32'h0000_0010);
    bus(1, 4'h0, 16'h0000);
    bus(1, 4'h1, 16'hB2C5);
    bus(0, 4'h1, 16'h0000);
    chk("adc fields", rd, 32'h0000_B2C5);
    bus(1, 4'h1, 16'hB000);
    results(2);
    bus(0, 4'hA, 16'h0000);
    chk("current uncal", rd, 32'h0000_0000);
    bus(0, 4'hB, 16'h0000);
    chk("power uncal", rd, 32'h0000_0000);
    bus(0, 4'h7, 16'h0000);
    chk("shunt result", rd, 32'h0000_0064);
    $display("test uncalibrated done");
    // Power limit 80 sits above power[23:8] = 78 but far below 20000
    bus(1, 4'h2, 16'h0800);
    bus(1, 4'h4, 16'h0032);
    bus(1, 4'h5, 16'h0384);
    bus(1, 4'h6, 16'h0050);
    // Restart puts shunt first; its fault must show within 1.5 periods
    bus(1, 4'h1, 16'hB000);
    lat = 0;
    while (ALERT_N !== 1'b0 && lat < (`CONV_BASE_CYC * 3) / 2)
    begin
      lat++;
      @(posedge CLK);
    end
    chk("alert latency", {31'h0, ALERT_N}, 32'h0000_0000);
    results(1);
    bus(0, 4'hA, 16'h0000);
    chk("current", rd, 32'h0000_0064);
    bus(0, 4'hB, 16'h0000);
    chk("power", rd, 32'h0000_4E20);
    bus(0, 4'hC, 16'h0000);
    chk("faults", {29'h0, rd[3:1]}, 32'h0000_0003);
    chk("alert fault", {31'h0, ALERT_N}, 32'h0000_0000);
    $display("test limits done");
    // Negative shunt on the narrow range, ready on the alert pin
    shunt_set <= 16'hFF9C;
    bus(1, 4'h0, 16'h0010);
    bus(1, 4'h3, 16'h0001);
    bus(1, 4'h6, 16'h004D);
    results(2);
    chk("alert ready", {31'h0, ALERT_N}, 32'h0000_0000);
    bus(0, 4'h7, 16'h0000);
    chk("shunt neg", {16'h0, rd[15:0]}, 32'h0000_FE70);
    bus(0, 4'hA, 16'h0000);
    chk("current neg", {16'h0, rd[15:0]}, 32'h0000_FE70);
    bus(0, 4'hC, 16'h0000);
    chk("faults neg", {29'h0, rd[3:1]}, 32'h0000_0006);
    repeat (2) @(posedge CLK);
    chk("alert cleared", {31'h0, ALERT_N}, 32'h0000_0001);
    $display("test negative done");
    // Mid-run power cycle drops the host settings
    RESETN <= 0;
    repeat (3) @(posedge CLK);
    RESETN <= 1;
    bus(0, 4'h4, 16'h0000);
    chk("limit again", rd, 32'h0000_7FFF);
    bus(0, 4'h2, 16'h0000);
    chk("calib again", rd, 32'h0000_0000);
    bus(1, 4'h2, 16'h0800);
    bus(0, 4'h2, 16'h0000);
    chk("calib rewritten", rd, 32'h0000_0800);
    $display("test power cycle done");
    final_report;
  end
endmodule
